// file: hw/fbod_host.sv
// Purpose: Host controller that runs read, write and reset cycles on a flash bus.
// Assumes: User holds request inputs stable while req_i is high.
// Notes: Bank, sector and command meaning live in the user's address and data.
`timescale 1ns/1ps
module fbod_host (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // User side
    input wire logic req_i,
    input wire fbod_pkg::fbod_op_t op_i,
    input wire logic byte_mode_i,
    input wire logic [fbod_pkg::ADDR_W:0] addr_i,
    input wire logic [fbod_pkg::DATA_W-1:0] wdata_i,
    output logic ready_o,
    output logic done_o,
    output logic [fbod_pkg::DATA_W-1:0] rdata_o,
    output logic busy_o,
    // Flash pins
    output logic [fbod_pkg::ADDR_W-1:0] fl_addr_o,
    input wire logic [fbod_pkg::DATA_W-1:0] fl_dq_i,
    output logic [fbod_pkg::DATA_W-1:0] fl_dq_o,
    output logic [fbod_pkg::DATA_W-1:0] fl_dq_oe_n_o,
    output logic fl_ce_n_o,
    output logic fl_oe_n_o,
    output logic fl_we_n_o,
    output logic fl_reset_n_o,
    output logic fl_word_mode_o,
    input wire logic ready_busy_out
);
    typedef enum logic [2:0] {
        S_RST,
        S_RECOV,
        S_IDLE,
        S_SETUP,
        S_STROBE,
        S_HOLD
    } fbod_state_t;

    typedef struct packed {
        fbod_state_t state;
        fbod_pkg::fbod_op_t op;
        logic byte_mode;
        logic [fbod_pkg::ADDR_W:0] addr;    // Bit 0 is the byte-mode low bit
        logic [fbod_pkg::DATA_W-1:0] wdata;
        logic [fbod_pkg::DATA_W-1:0] rdata;
        logic done;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
        logic drive;
    } fbod_host_t;

    fbod_host_t st_ff;      // Registered state
    fbod_host_t nxt_st;     // Next state
    logic tmr_load;         // Start a phase
    logic [fbod_pkg::CNT_W-1:0] tmr_val;    // Phase length
    logic tmr_done;         // Phase elapsed

    // Word address on pins: in byte mode the low bit leaves on the top data pin
    function automatic logic [fbod_pkg::ADDR_W-1:0] pin_addr(
        input logic [fbod_pkg::ADDR_W:0] a
    );
        pin_addr = a[fbod_pkg::ADDR_W:1];
    endfunction

    fbod_phase_timer u_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .load_i(tmr_load),
        .value_i(tmr_val),
        .done_o(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: reset pulse, recovery, then one phased cycle per request
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        tmr_load = 1'b0;
        tmr_val = fbod_pkg::CNT_ZERO;
        case (st_ff.state)
            S_RST: begin
                // Hold the device reset; it floats and returns to read array
                nxt_st.reset_n = 1'b0;
                nxt_st.ce_n = 1'b1;
                nxt_st.oe_n = 1'b1;
                nxt_st.we_n = 1'b1;
                nxt_st.drive = 1'b0;
                if (tmr_done) begin
                    nxt_st.reset_n = 1'b1;
                    nxt_st.state = S_RECOV;
                    tmr_load = 1'b1;
                    tmr_val = fbod_pkg::RECOV_CYC;
                end
            end
            S_RECOV: begin
                // Device is in read array now, no command needed
                if (tmr_done) begin
                    nxt_st.state = S_IDLE;
                    nxt_st.done = (st_ff.op == fbod_pkg::FBOD_OP_RESET);
                end
            end
            S_IDLE: begin
                // Bus idles in standby with outputs floated
                nxt_st.ce_n = 1'b1;
                if (req_i) begin
                    nxt_st.op = op_i;
                    nxt_st.byte_mode = byte_mode_i;
                    nxt_st.addr = addr_i;
                    nxt_st.wdata = wdata_i;
                    if (op_i == fbod_pkg::FBOD_OP_RESET) begin
                        nxt_st.state = S_RST;
                        tmr_load = 1'b1;
                        tmr_val = fbod_pkg::RST_CYC;
                    end else begin
                        nxt_st.state = S_SETUP;
                        nxt_st.ce_n = 1'b0;
                        // Writes drive data; reads leave the data pins, bar the top pin in byte mode, and send no command
                        nxt_st.drive = (op_i == fbod_pkg::FBOD_OP_WRITE);
                        tmr_load = 1'b1;
                        tmr_val = fbod_pkg::SETUP_CYC;
                    end
                end
            end
            S_SETUP: begin
                if (tmr_done) begin
                    nxt_st.state = S_STROBE;
                    if (st_ff.op == fbod_pkg::FBOD_OP_WRITE) begin
                        nxt_st.we_n = 1'b0;
                        nxt_st.oe_n = 1'b1;
                    end else begin
                        nxt_st.oe_n = 1'b0;
                        nxt_st.we_n = 1'b1;
                    end
                    tmr_load = 1'b1;
                    tmr_val = fbod_pkg::STROBE_CYC;
                end
            end
            S_STROBE: begin
                if (tmr_done) begin
                    // Sample read data while gate still low
                    if (st_ff.op == fbod_pkg::FBOD_OP_READ) begin
                        if (st_ff.byte_mode) begin
                            nxt_st.rdata = {8'h00, fl_dq_i[7:0]};
                        end else begin
                            nxt_st.rdata = fl_dq_i;
                        end
                    end
                    nxt_st.oe_n = 1'b1;
                    nxt_st.we_n = 1'b1;
                    nxt_st.state = S_HOLD;
                    tmr_load = 1'b1;
                    tmr_val = fbod_pkg::HOLD_CYC;
                end
            end
            S_HOLD: begin
                // Hold address and data, then release the bus
                if (tmr_done) begin
                    nxt_st.ce_n = 1'b1;
                    nxt_st.drive = 1'b0;
                    nxt_st.done = 1'b1;
                    nxt_st.state = S_IDLE;
                end
            end
            default: begin
                nxt_st.state = S_IDLE;
            end
        endcase
    end

    // Register stage; reset also pulses the device reset pin
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Timer sits at zero, so the first edge releases the pin into recovery
            st_ff.state <= S_RST;
            st_ff.op <= fbod_pkg::FBOD_OP_READ;
            st_ff.byte_mode <= 1'b0;
            st_ff.addr <= '0;
            st_ff.wdata <= fbod_pkg::DATA_ZERO;
            st_ff.rdata <= fbod_pkg::DATA_ZERO;
            st_ff.done <= 1'b0;
            st_ff.ce_n <= 1'b1;
            st_ff.oe_n <= 1'b1;
            st_ff.we_n <= 1'b1;
            st_ff.reset_n <= 1'b0;
            st_ff.drive <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    assign fl_addr_o = pin_addr(st_ff.addr);
    assign fl_ce_n_o = st_ff.ce_n;
    assign fl_oe_n_o = st_ff.oe_n;
    assign fl_we_n_o = st_ff.we_n;
    assign fl_reset_n_o = st_ff.reset_n;
    assign fl_word_mode_o = ~st_ff.byte_mode;

    // Byte mode: top pin carries the low address bit while selected and out of reset, middle pins float
    always_comb begin
        fl_dq_o = st_ff.wdata;
        fl_dq_oe_n_o = {fbod_pkg::DATA_W{1'b1}};
        if (st_ff.byte_mode) begin
            fl_dq_o = {st_ff.addr[0], 7'h00, st_ff.wdata[7:0]};
            fl_dq_oe_n_o[15] = ~(st_ff.reset_n & ~st_ff.ce_n);
            fl_dq_oe_n_o[7:0] = {8{~st_ff.drive}};
        end else begin
            fl_dq_oe_n_o = {fbod_pkg::DATA_W{~st_ff.drive}};
        end
    end

    // Multi-write sequences such as bypass or erase are issued by the user
    assign ready_o = (st_ff.state == S_IDLE);
    assign done_o = st_ff.done;
    assign rdata_o = st_ff.rdata;
    assign busy_o = ~ready_busy_out;
endmodule

// file: hw/fbod_pkg.sv
// Purpose: Shared constants for the parallel flash bus host controller.
// Assumes: 100 MHz clock, one request at a time from the user side.
// Notes: Pin timing figures are conservative defaults, not device figures.
package fbod_pkg;
    localparam int ADDR_W = 18;         // Word address width
    localparam int DATA_W = 16;         // Data pin count
    localparam int CNT_W = 8;           // Phase counter width
    localparam int CLK_NS = 10;         // Clock period
    localparam int T_SETUP_NS = 20;     // Address/data setup before strobe
    localparam int T_STROBE_NS = 120;   // Strobe low time, covers slowest access
    localparam int T_HOLD_NS = 20;      // Hold and bus turnaround after strobe
    localparam int T_RST_NS = 500;      // Reset pulse width
    localparam int T_RECOV_NS = 500;    // Time after reset release before access
    localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RST_CYC = CNT_W'((T_RST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RECOV_CYC = CNT_W'((T_RECOV_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;
    localparam int BANK_MSB = 17;       // Bank and sector bits sit at the top
    localparam int SECT_LSB = 12;
    typedef enum logic [1:0] {
        FBOD_OP_READ,
        FBOD_OP_WRITE,
        FBOD_OP_RESET
    } fbod_op_t;
endpackage

// file: hw/fbod_phase_timer.sv
// Purpose: Down counter that times each bus phase.
// Assumes: Load only arrives in a cycle where done is high.
// Notes: Done is a level while the count sits at zero.
`timescale 1ns/1ps
module fbod_phase_timer (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [fbod_pkg::CNT_W-1:0] value_i,
    output logic done_o
);
    typedef struct packed {
        logic [fbod_pkg::CNT_W-1:0] cnt;
    } fbod_tmr_t;

    fbod_tmr_t st_ff;   // Registered count
    fbod_tmr_t nxt_st;  // Next count

    ////////////////////////////////////////////////////////////////////////
    // Load wins, otherwise count down to zero
    always_comb begin
        nxt_st = st_ff;
        if (load_i) begin
            nxt_st.cnt = value_i;
        end else if (st_ff.cnt != fbod_pkg::CNT_ZERO) begin
            nxt_st.cnt = st_ff.cnt - fbod_pkg::CNT_W'(1);
        end
    end

    // Register stage
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done_o = (st_ff.cnt == fbod_pkg::CNT_ZERO);
endmodule

// file: verif/fbod_host_asserts.sv
// Purpose: Pin protocol checks for the flash bus host controller.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound onto fbod_host; sees only its ports.
`timescale 1ns/1ps
module fbod_host_asserts (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic ready_o,
    input wire logic byte_mode_i,
    input wire logic [fbod_pkg::ADDR_W:0] addr_i,
    input wire logic [fbod_pkg::ADDR_W-1:0] fl_addr_o,
    input wire logic [fbod_pkg::DATA_W-1:0] fl_dq_oe_n_o,
    input wire logic fl_ce_n_o,
    input wire logic fl_oe_n_o,
    input wire logic fl_we_n_o,
    input wire logic fl_reset_n_o,
    input wire logic fl_word_mode_o
);
    logic [fbod_pkg::ADDR_W-1:0] word_addr; // Word part of the user address
    assign word_addr = addr_i[fbod_pkg::ADDR_W:1];
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////
    a_no_overlap: assert property (fl_we_n_o || fl_oe_n_o)
        else $error("write strobe and output gate low together");
    a_read_select: assert property (!fl_oe_n_o |-> !fl_ce_n_o && fl_we_n_o)
        else $error("gate low without select or with strobe");
    a_write_levels: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o
        && fl_dq_oe_n_o[7:0] == 8'h00)
        else $error("write levels wrong");
    a_read_float: assert property (!fl_oe_n_o |-> fl_dq_oe_n_o[14:0] == 15'h7FFF)
        else $error("host drives data during read");
    a_strobe_len: assert property ($fell(fl_oe_n_o) |-> !fl_oe_n_o [*8])
        else $error("read gate too short");
    a_word_width: assert property (req_i && ready_o |=> fl_word_mode_o == !$past(byte_mode_i))
        else $error("width select wrong");
    a_byte_float: assert property (!fl_word_mode_o |-> fl_dq_oe_n_o[14:8] == 7'h7F)
        else $error("middle data lines driven in byte mode");
    a_low_addr: assert property (!fl_word_mode_o && !fl_ce_n_o |-> !fl_dq_oe_n_o[15])
        else $error("low address line not driven");
    a_addr_load: assert property ($fell(fl_ce_n_o) |-> fl_addr_o == $past(word_addr))
        else $error("address not taken from request");
    a_reset_pulse: assert property ($fell(fl_reset_n_o) |-> !fl_reset_n_o [*8])
        else $error("device reset pulse too short");
    a_idle_select: assert property (ready_o |-> fl_ce_n_o)
        else $error("device selected while idle");
    c_read: cover property ($fell(fl_oe_n_o));
    c_write: cover property ($fell(fl_we_n_o));
    c_reset: cover property ($fell(fl_reset_n_o));
endmodule
bind fbod_host fbod_host_asserts u_asserts (.clock_i, .rst_n_i, .req_i, .ready_o,
    .byte_mode_i, .addr_i, .fl_addr_o, .fl_dq_oe_n_o, .fl_ce_n_o, .fl_oe_n_o,
    .fl_we_n_o, .fl_reset_n_o, .fl_word_mode_o);

// file: verif/fbod_flash_model.sv
// Purpose: Behavioural flash device on the host pins.
// Assumes: Host pins are registered; writes latch as the strobe falls.
// Notes: Commands trimmed to program, identify and read-array.
`timescale 1ns/1ps
module fbod_flash_model #(
    parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary identification value
) (
    input wire logic [17:0] fl_addr_i,
    input wire logic [15:0] host_dq_i,
    input wire logic [15:0] host_oe_n_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic reset_n_i,
    input wire logic word_mode_i,
    output logic [15:0] bus_o,
    output logic ready_busy_o
);
    logic [15:0] mem [256] = '{default: 16'hFFFF}; // Erased cells read ones
    logic [1:0] st = 2'h0; // 0 read array, 1 program, 2 identify
    logic [15:0] flt = 16'hA5C3; // Undriven lines wander
    logic [15:0] w;
    logic [15:0] dout;
    initial ready_busy_o = 1'b1;
    always #5 flt = ~flt;
    // Read path and bus resolution
    always_comb begin
        w = mem[fl_addr_i[7:0]];
        if (st == 2'h2) dout = {8'h00, ID_CODE};
        else if (!word_mode_i) dout = {8'h00, host_dq_i[15] ? w[15:8] : w[7:0]};
        else dout = w;
        for (int b = 0; b < 16; b++) begin
            if (!host_oe_n_i[b]) bus_o[b] = host_dq_i[b];
            else if (!ce_n_i && !oe_n_i && reset_n_i && (word_mode_i || b < 8)) bus_o[b] = dout[b];
            else bus_o[b] = flt[b];
        end
    end
    // Command latch, not in the memory map; A0 starts a bypass program
    always @(negedge we_n_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st = 2'h0;
        end else if (!ce_n_i) begin
            if (st == 2'h1) begin
                if (word_mode_i) mem[fl_addr_i[7:0]] = host_dq_i;
                else if (host_dq_i[15]) mem[fl_addr_i[7:0]][15:8] = host_dq_i[7:0];
                else mem[fl_addr_i[7:0]][7:0] = host_dq_i[7:0];
                st = 2'h0;
                ready_busy_o = 1'b0;
                ready_busy_o <= #200 1'b1;
            end else if (host_dq_i[7:0] == 8'hA0) st = 2'h1;
            else if (host_dq_i[7:0] == 8'h90) st = 2'h2;
            else if (host_dq_i[7:0] == 8'hF0) st = 2'h0;
        end
    end
endmodule

// file: verif/fbod_host_test.sv
// Purpose: Self-checking bench for the flash bus host controller.
// Assumes: Flash model on the pins; inputs change on the falling edge.
// Notes: Table rows first, then busy and mid-run reset cases.
`timescale 1ns/1ps
module fbod_host_test;
    localparam fbod_pkg::fbod_op_t RD = fbod_pkg::FBOD_OP_READ;
    localparam fbod_pkg::fbod_op_t WR = fbod_pkg::FBOD_OP_WRITE;
    localparam fbod_pkg::fbod_op_t RS = fbod_pkg::FBOD_OP_RESET;
    typedef struct {fbod_pkg::fbod_op_t op; logic b; logic [18:0] a; logic [15:0] d;
        logic chk; logic [15:0] exp;} fbod_row_t;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_i = 1'b0;
    fbod_pkg::fbod_op_t op_i = RD;
    logic byte_mode_i = 1'b0;
    logic [18:0] addr_i = 19'h00000;
    logic [15:0] wdata_i = 16'h0000;
    logic ready_o, done_o, busy_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_reset_n_o;
    logic fl_word_mode_o, ready_busy_out;
    logic [15:0] rdata_o, fl_dq_i, fl_dq_o, fl_dq_oe_n_o;
    logic [17:0] fl_addr_o;
    int fail_count = 0;
    int total_checks = 0;
    fbod_row_t rows [14] = '{
        '{RD, 1'b0, 19'h00020, 16'h0000, 1'b1, 16'hFFFF},
        '{RD, 1'b0, 19'h7FF20, 16'h0000, 1'b1, 16'hFFFF},
        '{WR, 1'b0, 19'h00000, 16'h00A0, 1'b0, 16'h0000},
        '{WR, 1'b0, 19'h00020, 16'h1234, 1'b0, 16'h0000},
        '{RD, 1'b0, 19'h00020, 16'h0000, 1'b1, 16'h1234},
        '{RD, 1'b1, 19'h00021, 16'h0000, 1'b1, 16'h0012},
        '{RD, 1'b1, 19'h00020, 16'h0000, 1'b1, 16'h0034},
        '{WR, 1'b1, 19'h00000, 16'h00A0, 1'b0, 16'h0000},
        '{WR, 1'b1, 19'h00041, 16'h00AB, 1'b0, 16'h0000},
        '{RD, 1'b0, 19'h00040, 16'h0000, 1'b1, 16'hABFF},
        '{WR, 1'b0, 19'h00000, 16'h0090, 1'b0, 16'h0000},
        '{RD, 1'b0, 19'h00000, 16'h0000, 1'b1, 16'h005A},
        '{RS, 1'b0, 19'h00000, 16'h0000, 1'b0, 16'h0000},
        '{RD, 1'b0, 19'h00020, 16'h0000, 1'b1, 16'h1234}};
    fbod_host dut (.clock_i, .rst_n_i, .req_i, .op_i, .byte_mode_i, .addr_i, .wdata_i,
        .ready_o, .done_o, .rdata_o, .busy_o, .fl_addr_o, .fl_dq_i, .fl_dq_o, .fl_dq_oe_n_o,
        .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o, .fl_reset_n_o, .fl_word_mode_o, .ready_busy_out);
    fbod_flash_model flash (.fl_addr_i(fl_addr_o), .host_dq_i(fl_dq_o),
        .host_oe_n_i(fl_dq_oe_n_o), .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o),
        .we_n_i(fl_we_n_o), .reset_n_i(fl_reset_n_o), .word_mode_i(fl_word_mode_o),
        .bus_o(fl_dq_i), .ready_busy_o(ready_busy_out));
    always #5 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One request held until taken, then wait for done under a bound
    task automatic run(input fbod_pkg::fbod_op_t op, input logic b, input logic [18:0] a,
        input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clock_i);
        req_i = 1'b1;
        op_i = op;
        byte_mode_i = b;
        addr_i = a;
        wdata_i = d;
        while (done_o !== 1'b1 && n < 300) begin
            @(negedge clock_i);
            if (ready_o === 1'b0) req_i = 1'b0;
            n++;
        end
        if (n == 300) check(16'h0001, 16'h0000);
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 300) begin
            @(negedge clock_i);
            n++;
        end
        check({15'h0000, ready_o}, 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'b1;
        wait_ready();
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].b, rows[i].a, rows[i].d);
            if (rows[i].chk) check(rdata_o, rows[i].exp);
            check({10'h000, fl_addr_o[fbod_pkg::BANK_MSB:fbod_pkg::SECT_LSB]}, {10'h000, rows[i].a[18:13]});
        end
        // Program, then watch the device busy line come and go
        run(WR, 1'b0, 19'h00000, 16'h00A0);
        run(WR, 1'b0, 19'h00060, 16'h5555);
        check({15'h0000, busy_o}, 16'h0001);
        repeat (30) @(negedge clock_i);
        check({15'h0000, busy_o}, 16'h0000);
        // Mid-run reset parks the pins and resets the device
        rst_n_i = 1'b0;
        #1;
        check({11'h000, ready_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_reset_n_o}, 16'h000E);
        check(fl_dq_oe_n_o, 16'hFFFF);
        @(negedge clock_i);
        rst_n_i = 1'b1;
        wait_ready();
        run(RD, 1'b0, 19'h00060, 16'h0000);
        check(rdata_o, 16'h5555);
        report_and_stop();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        check(16'h0001, 16'h0000);
        report_and_stop();
    end
endmodule
